// *** core/mpo_pkg.sv ***
/*
  constants for the multi-channel pwm output stage: register indices,
  field positions, gate encodings and reset values.
  assumes a 32-bit apb slave where every register index maps to byte
  address index*4.
*/
package mpo_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_CH = 4;
  localparam int EDGE_W = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;

  // ----------------------------------------
  // register indices (byte address = index*4)
  // ----------------------------------------
  localparam logic [IDX_W-1:0] IDX_ENABLE_CTL = 10'h079;
  localparam logic [IDX_W-1:0] IDX_GATE_DT_CTL = 10'h07A;
  localparam logic [IDX_W-1:0] IDX_TRIP_CTL = 10'h07B;
  // rising value of channel x at base+2x, falling at base+2x+1
  localparam logic [IDX_W-1:0] IDX_EDGE_BASE = 10'h07C;
  localparam logic [IDX_W-1:0] IDX_EDGE_LAST = 10'h083;

  // ----------------------------------------
  // enable control fields
  // ----------------------------------------
  localparam int BIT_PAIR_EN = 7;
  localparam int BIT_TRIP_FEAT_EN = 6;
  localparam int BIT_SHARED_EN = 5;
  localparam int BIT_GEN_EN_LO = 1;
  localparam int BIT_MULTI_EN = 0;

  // ----------------------------------------
  // gate / dead-time fields
  // ----------------------------------------
  localparam int BIT_INV_GATE_LO = 6;
  localparam int BIT_TRUE_GATE_LO = 4;
  localparam int DT_W = 4;
  localparam logic [1:0] GATE_AND = 2'h1;
  localparam logic [1:0] GATE_OR = 2'h2;

  // ----------------------------------------
  // trip control fields
  // ----------------------------------------
  localparam int BIT_TRIP_SRC_LO = 4;
  localparam int BIT_TRIP_TRI = 3;
  localparam int BIT_TRIP_LVL_TRUE = 2;
  localparam int BIT_TRIP_LVL_INV = 1;
  localparam int BIT_TRIP_FLAG = 0;

  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [EDGE_W-1:0] EDGE_RESET = 16'h0000;
endpackage

// *** core/mpo_dead_time.sv ***
/*
  dead-time inserter for one complementary pair.
  assumes i_level comes from logic on the same clock; the delay field
  may change at any time and takes effect at the next level change.
*/
module mpo_dead_time (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [mpo_pkg::DT_W-1:0] i_delay,
  input wire logic i_level,
  output logic o_true,
  output logic o_inv
);
  typedef struct packed {
    logic lvl;
    logic [mpo_pkg::DT_W-1:0] cnt;
    logic t;
    logic n;
  } mpo_dt_s;

  mpo_dt_s q_ff;
  mpo_dt_s nxt_q;

  always_comb begin
    nxt_q = q_ff;
    if (i_level != q_ff.lvl) begin
      nxt_q.lvl = i_level;
      // falling side drops at once, rising side waits
      nxt_q.t = 1'b0;
      nxt_q.n = 1'b0;
      if (i_delay == '0) begin
        nxt_q.t = i_level;
        nxt_q.n = ~i_level;
      end else begin
        nxt_q.cnt = i_delay;
      end
    end else if (q_ff.cnt != '0) begin
      nxt_q.cnt = q_ff.cnt - 1'b1;
      if (q_ff.cnt == 4'h1) begin
        nxt_q.t = q_ff.lvl;
        nxt_q.n = ~q_ff.lvl;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q_ff <= '{lvl: 1'b0, cnt: '0, t: 1'b0, n: 1'b1};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_true = q_ff.t;
  assign o_inv = q_ff.n;
endmodule

// *** core/mpo_output_stage.sv ***
/*
  four-channel complementary pwm output stage with apb registers:
  edge compare with double buffering, gating, dead time, power trip.
  assumes a shared 16-bit down-counter whose value and decrement pulse
  arrive on the same clock; capture inputs come from pins.
*/
// The APB interface to the registers was left to the implementer.
// ----------------------------------------
// Overview of operation
// - multi-channel enable off, edge writes load directly
// - running, shadowed; swap at opposite transition
// - missed edge count waits for next pass
// - multi-channel global gating with port latch
// - true outputs: 01 and, 10 or
// - inverted outputs use same gate encoding
// - or forces high, and forces low
// - shared dead time before partner rises
// - four-bit field counts clock periods directly
// - enabled capture inputs ored force trip
// - trip sets detected flag to one
// - trip held until software writes zero
// - true and inverted groups tripped together, levels separate
// - level bit zero drives one, one zero
// - tristate select zero leaves outputs floating
// - bit 7 enables inverted outputs too
// - bit 6 enables the trip feature
// - bit 5 enables shared drive mode
// - shared mode routes generator zero everywhere
// - bits 4:1 enable generators 3..0
// - bit 0 multi-channel enable, reset zero
// ----------------------------------------
module mpo_output_stage (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [mpo_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [mpo_pkg::DATA_W-1:0] i_pwdata,
  output logic [mpo_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [mpo_pkg::EDGE_W-1:0] i_count,
  input wire logic i_count_tick,
  input wire logic [7:0] i_port_latch,
  input wire logic [3:0] i_capture,
  output logic [3:0] o_pwm_true,
  output logic [3:0] o_pwm_true_oe,
  output logic [3:0] o_pwm_inv,
  output logic [3:0] o_pwm_inv_oe
);
  localparam int N = mpo_pkg::NUM_CH;
  localparam int W = mpo_pkg::EDGE_W;

  typedef struct packed {
    logic [7:0] en_ctl;
    logic [7:0] gd_ctl;
    logic [7:0] trip_ctl;
    logic [N-1:0][W-1:0] rise_act;
    logic [N-1:0][W-1:0] fall_act;
    logic [N-1:0][W-1:0] rise_sh;
    logic [N-1:0][W-1:0] fall_sh;
    logic [N-1:0] rise_pend;
    logic [N-1:0] fall_pend;
    logic [N-1:0] level;
    logic [3:0] cap_s1;
    logic [3:0] cap_s2;
    logic [mpo_pkg::DATA_W-1:0] rdata;
    logic ready;
    logic slverr;
    logic [N-1:0] pt;
    logic [N-1:0] pt_oe;
    logic [N-1:0] pn;
    logic [N-1:0] pn_oe;
  } mpo_state_s;

  mpo_state_s q_ff;
  mpo_state_s nxt_q;
  logic [N-1:0] dt_true;
  logic [N-1:0] dt_inv;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic gate(input logic [1:0] sel, input logic v,
                                input logic latch);
    case (sel)
      mpo_pkg::GATE_AND: gate = v & latch;
      mpo_pkg::GATE_OR: gate = v | latch;
      default: gate = v;
    endcase
  endfunction

  function automatic logic is_edge(input logic [mpo_pkg::IDX_W-1:0] idx);
    is_edge = (idx >= mpo_pkg::IDX_EDGE_BASE) && (idx <= mpo_pkg::IDX_EDGE_LAST);
  endfunction

  // ----------------------------------------
  // dead-time per pair
  // ----------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_dt
    mpo_dead_time u_dt (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_delay(q_ff.gd_ctl[mpo_pkg::DT_W-1:0]),
      .i_level(q_ff.level[g]),
      .o_true(dt_true[g]),
      .o_inv(dt_inv[g])
    );
  end

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    logic [mpo_pkg::IDX_W-1:0] idx;
    logic [mpo_pkg::IDX_W-1:0] eoff;
    logic setup;
    logic wr;
    logic running;
    logic [N-1:0] gen_on;
    logic trip_feat;
    logic trip_in;
    logic trip_act;
    int ch;
    int src;
    idx = i_paddr[mpo_pkg::ADDR_W-1:2];
    eoff = idx - mpo_pkg::IDX_EDGE_BASE;
    setup = i_psel & ~i_penable;
    wr = i_psel & i_penable & q_ff.ready & i_pwrite;
    ch = 0;
    src = 0;
    nxt_q = q_ff;
    running = q_ff.en_ctl[mpo_pkg::BIT_MULTI_EN];
    gen_on = q_ff.en_ctl[mpo_pkg::BIT_GEN_EN_LO +: N] & {N{running}};
    trip_feat = q_ff.en_ctl[mpo_pkg::BIT_TRIP_FEAT_EN];

    // capture inputs cross from pins
    nxt_q.cap_s1 = i_capture;
    nxt_q.cap_s2 = q_ff.cap_s1;

    // edge compare; a value already passed simply waits for the
    // next pass of the counter
    for (int x = 0; x < N; x++) begin
      if (!gen_on[x]) begin
        nxt_q.level[x] = 1'b0;
      end else if (i_count_tick) begin
        if (!q_ff.level[x] && i_count == q_ff.rise_act[x]) begin
          nxt_q.level[x] = 1'b1;
          if (q_ff.fall_pend[x]) begin
            nxt_q.fall_act[x] = q_ff.fall_sh[x];
            nxt_q.fall_pend[x] = 1'b0;
          end
        end else if (q_ff.level[x] && i_count == q_ff.fall_act[x]) begin
          nxt_q.level[x] = 1'b0;
          if (q_ff.rise_pend[x]) begin
            nxt_q.rise_act[x] = q_ff.rise_sh[x];
            nxt_q.rise_pend[x] = 1'b0;
          end
        end
      end
    end

    // apb: zero wait states, read data sampled in the setup cycle
    nxt_q.ready = setup;
    // response fields stand for the single access cycle only
    nxt_q.slverr = 1'b0;
    nxt_q.rdata = '0;
    if (setup) begin
      ch = 32'(eoff[2:1]);
      if (idx == mpo_pkg::IDX_ENABLE_CTL) begin
        nxt_q.rdata[7:0] = q_ff.en_ctl;
      end else if (idx == mpo_pkg::IDX_GATE_DT_CTL) begin
        nxt_q.rdata[7:0] = q_ff.gd_ctl;
      end else if (idx == mpo_pkg::IDX_TRIP_CTL) begin
        nxt_q.rdata[7:0] = q_ff.trip_ctl;
      end else if (is_edge(idx)) begin
        nxt_q.rdata[W-1:0] = eoff[0] ? q_ff.fall_act[ch] : q_ff.rise_act[ch];
      end else begin
        nxt_q.slverr = 1'b1;
      end
    end

    if (wr) begin
      ch = 32'(eoff[2:1]);
      if (idx == mpo_pkg::IDX_ENABLE_CTL) begin
        nxt_q.en_ctl = i_pwdata[7:0];
      end else if (idx == mpo_pkg::IDX_GATE_DT_CTL) begin
        nxt_q.gd_ctl = i_pwdata[7:0];
      end else if (idx == mpo_pkg::IDX_TRIP_CTL) begin
        nxt_q.trip_ctl[7:1] = i_pwdata[7:1];
        // the flag is read-only except that a zero clears it
        if (!i_pwdata[mpo_pkg::BIT_TRIP_FLAG]) begin
          nxt_q.trip_ctl[mpo_pkg::BIT_TRIP_FLAG] = 1'b0;
        end
      end else if (is_edge(idx)) begin
        if (!running) begin
          if (eoff[0]) begin
            nxt_q.fall_act[ch] = i_pwdata[W-1:0];
            nxt_q.fall_pend[ch] = 1'b0;
          end else begin
            nxt_q.rise_act[ch] = i_pwdata[W-1:0];
            nxt_q.rise_pend[ch] = 1'b0;
          end
        end else if (eoff[0]) begin
          nxt_q.fall_sh[ch] = i_pwdata[W-1:0];
          nxt_q.fall_pend[ch] = 1'b1;
        end else begin
          nxt_q.rise_sh[ch] = i_pwdata[W-1:0];
          nxt_q.rise_pend[ch] = 1'b1;
        end
      end
    end

    // power trip: set wins over a clearing write in the same cycle
    trip_in = |(q_ff.cap_s2 & q_ff.trip_ctl[mpo_pkg::BIT_TRIP_SRC_LO +: 4]);
    if (trip_feat && trip_in) begin
      nxt_q.trip_ctl[mpo_pkg::BIT_TRIP_FLAG] = 1'b1;
    end
    trip_act = trip_feat & q_ff.trip_ctl[mpo_pkg::BIT_TRIP_FLAG];

    // output composition
    for (int x = 0; x < N; x++) begin
      src = q_ff.en_ctl[mpo_pkg::BIT_SHARED_EN] ? 0 : x;
      nxt_q.pt_oe[x] = gen_on[x];
      nxt_q.pn_oe[x] = gen_on[x] & q_ff.en_ctl[mpo_pkg::BIT_PAIR_EN];
      nxt_q.pt[x] = gen_on[x] & gate(q_ff.gd_ctl[mpo_pkg::BIT_TRUE_GATE_LO +: 2],
                                     dt_true[src], i_port_latch[x]);
      nxt_q.pn[x] = nxt_q.pn_oe[x] & gate(q_ff.gd_ctl[mpo_pkg::BIT_INV_GATE_LO +: 2],
                                          dt_inv[src], i_port_latch[x+N]);
      if (trip_act) begin
        if (q_ff.trip_ctl[mpo_pkg::BIT_TRIP_TRI]) begin
          nxt_q.pt[x] = ~q_ff.trip_ctl[mpo_pkg::BIT_TRIP_LVL_TRUE];
          nxt_q.pn[x] = ~q_ff.trip_ctl[mpo_pkg::BIT_TRIP_LVL_INV];
        end else begin
          // released to the pull-up of the power stage
          nxt_q.pt[x] = 1'b0;
          nxt_q.pn[x] = 1'b0;
          nxt_q.pt_oe[x] = 1'b0;
          nxt_q.pn_oe[x] = 1'b0;
        end
        if (!gen_on[x]) begin
          nxt_q.pt[x] = 1'b0;
          nxt_q.pn[x] = 1'b0;
        end
        if (!nxt_q.pn_oe[x] && !q_ff.trip_ctl[mpo_pkg::BIT_TRIP_TRI]) begin
          nxt_q.pn[x] = 1'b0;
        end
        nxt_q.pn_oe[x] = nxt_q.pn_oe[x] & gen_on[x] &
                         q_ff.en_ctl[mpo_pkg::BIT_PAIR_EN];
        nxt_q.pn[x] = nxt_q.pn[x] & nxt_q.pn_oe[x];
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q_ff <= '0;
      q_ff.en_ctl <= mpo_pkg::CTL_RESET;
      q_ff.gd_ctl <= mpo_pkg::CTL_RESET;
      q_ff.trip_ctl <= mpo_pkg::CTL_RESET;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_prdata = q_ff.rdata;
  assign o_pready = q_ff.ready;
  assign o_pslverr = q_ff.slverr;
  assign o_pwm_true = q_ff.pt;
  assign o_pwm_true_oe = q_ff.pt_oe;
  assign o_pwm_inv = q_ff.pn;
  assign o_pwm_inv_oe = q_ff.pn_oe;
endmodule

// *** test/mpo_output_stage_chk.sv ***
/*
  port assertions for the pwm output stage.
  assumes one clock and an active-low async reset.
*/
module mpo_chk (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [3:0] i_capture,
  input wire logic [3:0] o_pwm_true,
  input wire logic [3:0] o_pwm_true_oe,
  input wire logic [3:0] o_pwm_inv,
  input wire logic [3:0] o_pwm_inv_oe
);
  // ----------
  // register shadows
  // ----------
  logic [7:0] en_ff, trip_ff, cur, any;
  logic [23:0] hist_ff;
  logic wr, hit;
  assign wr = i_psel & i_penable & i_pwrite & o_pready;
  assign cur = {en_ff[4:1] & {4{en_ff[0] & en_ff[7]}}, en_ff[4:1] & {4{en_ff[0]}}};
  // pins lag the register by a few edges
  assign any = cur | hist_ff[7:0] | hist_ff[15:8] | hist_ff[23:16];
  assign hit = (|(i_capture & trip_ff[7:4])) & en_ff[6];
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_ff <= 8'h00;
      trip_ff <= 8'h00;
      hist_ff <= 24'h000000;
    end else begin
      if (wr && i_paddr[11:2] == mpo_pkg::IDX_ENABLE_CTL) begin
        en_ff <= i_pwdata[7:0];
      end
      if (wr && i_paddr[11:2] == mpo_pkg::IDX_TRIP_CTL) begin
        trip_ff <= i_pwdata[7:0];
      end
      hist_ff <= {hist_ff[15:0], cur};
    end
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  apb_answer_a: assert property (
    i_psel && !i_penable |=> o_pready ##1 !o_pready) else $error("bad pready");
  err_ready_a: assert property (o_pslverr |-> o_pready) else $error("lone pslverr");
  reset_off_a: assert property (
    $rose(i_reset_n) |-> (o_pwm_true_oe | o_pwm_inv_oe) == 4'h0) else $error("on at reset");
  true_enable_a: assert property (
    (o_pwm_true_oe & ~any[3:0]) == 4'h0) else $error("true on while off");
  inv_enable_a: assert property (
    (o_pwm_inv_oe & ~any[7:4]) == 4'h0) else $error("inverted on while off");
  trip_true_a: assert property (
    (hit && trip_ff[3]) [*5] |-> o_pwm_true == (trip_ff[2] ? 4'h0 : o_pwm_true_oe))
    else $error("bad true trip level");
  trip_inv_a: assert property (
    (hit && trip_ff[3]) [*5] |-> o_pwm_inv == (trip_ff[1] ? 4'h0 : o_pwm_inv_oe))
    else $error("bad inverted trip level");
  trip_float_a: assert property (
    (hit && !trip_ff[3]) [*5] |-> (o_pwm_true_oe | o_pwm_inv_oe) == 4'h0)
    else $error("tripped pins driven");
  cover property (hit);
  cover property (o_pslverr);
  cover property (o_pwm_true_oe[0] && o_pwm_inv_oe[0]);
endmodule

// *** test/mpo_motor_model.sv ***
/*
  motor power stage at the pwm pins: fault sense and leg short count.
  assumes the bench commands faults on the same clock.
*/
module mpo_motor_model (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_fault,
  input wire logic [3:0] i_high,
  input wire logic [3:0] i_high_oe,
  input wire logic [3:0] i_low,
  input wire logic [3:0] i_low_oe,
  output logic o_sense,
  output logic [15:0] o_overlaps
);
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sense <= 1'h0;
      o_overlaps <= 16'h0000;
    end else begin
      // sense comparator answers one clock late
      o_sense <= i_fault;
      if ((i_high & i_high_oe & i_low & i_low_oe) != 4'h0) begin
        // both switches of a leg on shorts the supply
        o_overlaps <= o_overlaps + 16'h0001;
      end
    end
  end
endmodule

// *** test/tb_multi_pwm_output_stage.sv ***
/*
  bench for the output stage: apb tasks, shared counter, motor model.
  assumes the design answers every apb access.
*/
module tb_multi_pwm_output_stage;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, pen, pwr, tick, fault, sense, run, err, rdy, slv;
  logic [11:0] addr;
  logic [31:0] wdat, rdat, rd;
  logic [15:0] cnt, ovl;
  logic [7:0] latch;
  logic [3:0] tru, tru_oe, inv, inv_oe;
  logic [7:0] dts [3] = '{8'h00, 8'h03, 8'h0F};
  logic [7:0] tcfg [3] = '{8'h2A, 8'h22, 8'h2C};
  logic [3:0] texp [3] = '{4'hD, 4'h0, 4'h7};
  int fails, checks, n;
  int cyc = 0;
  mpo_output_stage dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(rdat), .o_pready(rdy),
    .o_pslverr(slv), .i_count(cnt), .i_count_tick(tick), .i_port_latch(latch),
    .i_capture({2'h0, sense, 1'h0}), .o_pwm_true(tru), .o_pwm_true_oe(tru_oe),
    .o_pwm_inv(inv), .o_pwm_inv_oe(inv_oe));
  mpo_motor_model motor (.i_core_clk(clk), .i_reset_n(rst_n), .i_fault(fault), .i_high(tru),
    .i_high_oe(tru_oe), .i_low(inv), .i_low_oe(inv_oe), .o_sense(sense), .o_overlaps(ovl));
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tick <= run;
    if (!rst_n) begin
      cnt <= 16'h003F;
    end else if (run) begin
      cnt <= (cnt == 16'h0000) ? 16'h003F : cnt - 16'h0001;
    end
    if (cyc == 5000) begin
      fails = fails + 1;
      results();
    end
  end
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, addr, wdat} <= {1'h1, 1'h0, w, idx, 2'h0, d};
    @(posedge clk);
    pen <= 1'h1;
    // pready is taken at the rising edge, together with the answer
    do @(posedge clk); while (rdy !== 1'h1);
    rd = rdat;
    err = slv;
    {psel, pen} <= 2'h0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic waitc(input logic [15:0] v);
    do @(negedge clk); while (cnt !== v);
  endtask
  initial begin
    {rst_n, psel, pen, pwr, run, fault, addr, wdat} = '0;
    latch = 8'h00;
    fails = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h0, mpo_pkg::IDX_ENABLE_CTL, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 10'h000, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'h1, mpo_pkg::IDX_EDGE_BASE, 32'h28);
    apb(1'h1, mpo_pkg::IDX_EDGE_BASE + 10'h001, 32'h0A);
    apb(1'h0, mpo_pkg::IDX_EDGE_BASE, 32'h0);
    chk(rd, 32'h28);
    apb(1'h1, mpo_pkg::IDX_ENABLE_CTL, 32'h83);
    apb(1'h0, mpo_pkg::IDX_ENABLE_CTL, 32'h0);
    chk(rd, 32'h83);
    run <= 1'h1;
    waitc(16'h001E);
    apb(1'h1, mpo_pkg::IDX_EDGE_BASE, 32'h32);
    apb(1'h0, mpo_pkg::IDX_EDGE_BASE, 32'h0);
    chk(rd, 32'h28);
    waitc(16'h0005);
    apb(1'h0, mpo_pkg::IDX_EDGE_BASE, 32'h0);
    chk(rd, 32'h32);
    $display("test registers and shadow done");
    foreach (dts[i]) begin
      apb(1'h1, mpo_pkg::IDX_GATE_DT_CTL, 32'(dts[i]));
      do @(negedge clk); while (!(tru[0] === 1'h0 && inv[0] === 1'h1));
      do @(negedge clk); while (inv[0] !== 1'h0);
      for (n = 0; tru[0] !== 1'h1; n++) @(negedge clk);
      chk(32'(n), 32'(dts[i]));
    end
    chk(32'(ovl), 32'h0);
    $display("test dead time done");
    do @(negedge clk); while (!(tru[0] === 1'h0 && inv[0] === 1'h1));
    @(posedge clk);
    {run, latch} <= {1'h0, 8'h01};
    for (int g = 0; g < 4; g++) begin
      // g*50h puts the same code in both gate fields
      apb(1'h1, mpo_pkg::IDX_GATE_DT_CTL, 32'(g * 8'h50));
      repeat (3) @(negedge clk);
      chk(32'(tru[0]), 32'(g == 2));
      chk(32'(inv[0]), 32'(g != 1));
    end
    apb(1'h1, mpo_pkg::IDX_GATE_DT_CTL, 32'h0);
    run <= 1'h1;
    $display("test gating done");
    apb(1'h1, mpo_pkg::IDX_ENABLE_CTL, 32'hC3);
    foreach (tcfg[i]) begin
      apb(1'h1, mpo_pkg::IDX_TRIP_CTL, 32'(tcfg[i]));
      fault <= 1'h1;
      // long enough for the checker's five-cycle trip window
      repeat (8) @(posedge clk);
      fault <= 1'h0;
      repeat (80) @(negedge clk);
      chk(32'({tru[0], tru_oe[0], inv[0], inv_oe[0]}), 32'(texp[i]));
      apb(1'h0, mpo_pkg::IDX_TRIP_CTL, 32'h0);
      chk(rd, 32'(tcfg[i]) | 32'h1);
      apb(1'h1, mpo_pkg::IDX_TRIP_CTL, 32'(tcfg[i]));
      apb(1'h0, mpo_pkg::IDX_TRIP_CTL, 32'h0);
      chk(rd, 32'(tcfg[i]));
    end
    $display("test trip done");
    apb(1'h1, mpo_pkg::IDX_ENABLE_CTL, 32'hBF);
    repeat (4) @(negedge clk);
    repeat (70) begin
      @(negedge clk);
      chk(32'({tru, inv}), 32'({{4{tru[0]}}, {4{inv[0]}}}));
    end
    apb(1'h1, mpo_pkg::IDX_ENABLE_CTL, 32'h85);
    repeat (4) @(negedge clk);
    chk(32'({tru_oe, inv_oe}), 32'h22);
    apb(1'h1, mpo_pkg::IDX_ENABLE_CTL, 32'h05);
    repeat (4) @(negedge clk);
    chk(32'({tru_oe, inv_oe}), 32'h20);
    $display("test shared drive done");
    results();
  end
endmodule
bind mpo_output_stage mpo_chk chk_i (.i_core_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .i_capture, .o_pwm_true, .o_pwm_true_oe,
  .o_pwm_inv, .o_pwm_inv_oe);
